/* File: verilog/swdt_target.sv */
// Serial wire debug target end with an Avalon-MM register port
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/10ps

module swdt_target (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic swclk_in,
   input wire logic swdio_in,
   output logic swdio_out,
   output logic swdio_oe_out,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);

   swdt_pkg::swdt_state_type s_q;
   swdt_pkg::swdt_state_type s_d;
   logic rise_w;
   logic din_w;
   logic hdr_bad_w;

   function automatic logic par32(input logic [31:0] v);
      par32 = ^v;
   endfunction : par32

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      be_merge = r;
   endfunction : be_merge

   // Outcome of earlier work decides this packet's answer
   function automatic logic [2:0] pick_ack(input swdt_pkg::swdt_state_type s);
      if (s.fault_pend) begin
         pick_ack = swdt_pkg::ACK_FAULT;
      end else if (s.ctrl[swdt_pkg::CTRL_HOLD_BIT] |
                   (s.ctrl[swdt_pkg::CTRL_WPEND_BIT] & s.pend)) begin
         pick_ack = swdt_pkg::ACK_WAIT;
      end else begin
         pick_ack = swdt_pkg::ACK_OK;
      end
   endfunction : pick_ack

   // Clock pin passes three flops, data pin two; edges come from the second and third stage
   assign rise_w = s_q.clk_sync[1] & ~s_q.clk_sync[2];
   assign din_w = s_q.dio_sync[1];
   assign hdr_bad_w = rise_w && (s_q.st == swdt_pkg::SWDT_HDR) && (s_q.cnt == swdt_pkg::HDR_LAST)
      && ((^s_q.hdr[swdt_pkg::HDR_A3:swdt_pkg::HDR_APNDP]) != s_q.hdr[swdt_pkg::HDR_PAR]
          || s_q.hdr[swdt_pkg::HDR_STOP] || !din_w);

   always_comb begin
      s_d = s_q;
      s_d.clk_sync = {s_q.clk_sync[1:0], swclk_in};
      s_d.dio_sync = {s_q.dio_sync[0], swdio_in};

      // Avalon slave: one wait cycle, then the access completes
      s_d.av_ack = (avs_read_in | avs_write_in) & ~s_q.av_ack;
      if (avs_read_in && !s_q.av_ack) begin
         unique case (avs_address_in)
            swdt_pkg::OFS_CTRL: s_d.av_rdata = {30'h0, s_q.ctrl};
            swdt_pkg::OFS_STATUS: s_d.av_rdata = {20'h0, s_q.last_hdr, 2'h0,
               s_q.in_lreset, s_q.fault_pend, s_q.sts_lrst, s_q.sts_herr,
               s_q.sts_perr, s_q.pend};
            swdt_pkg::OFS_RDATA: s_d.av_rdata = s_q.rdata;
            swdt_pkg::OFS_WDATA: s_d.av_rdata = s_q.wdata;
            default: s_d.av_rdata = 32'h0;
         endcase
      end
      if (avs_write_in && s_q.av_ack) begin
         unique case (avs_address_in)
            swdt_pkg::OFS_CTRL: begin
               if (avs_byteenable_in[0]) begin
                  s_d.ctrl = avs_writedata_in[1:0];
               end
            end
            swdt_pkg::OFS_STATUS: begin
               if (avs_byteenable_in[0]) begin
                  // Write one to clear; link events below still win
                  s_d.pend = s_q.pend & ~avs_writedata_in[swdt_pkg::STS_PEND_BIT];
                  s_d.sts_perr = s_q.sts_perr & ~avs_writedata_in[swdt_pkg::STS_PERR_BIT];
                  s_d.sts_herr = s_q.sts_herr & ~avs_writedata_in[swdt_pkg::STS_HERR_BIT];
                  s_d.sts_lrst = s_q.sts_lrst & ~avs_writedata_in[swdt_pkg::STS_LRST_BIT];
               end
            end
            swdt_pkg::OFS_RDATA: s_d.rdata = be_merge(s_q.rdata, avs_writedata_in,
                                                      avs_byteenable_in);
            default: ;
         endcase
      end

      // Link side, stepped once per rising edge of the host clock
      if (rise_w) begin
         if (!din_w) begin
            s_d.hi_cnt = 6'h0;
         end else if (s_q.hi_cnt != swdt_pkg::LRESET_CLOCKS) begin
            s_d.hi_cnt = s_q.hi_cnt + 6'h1;
         end
         s_d.cnt = s_q.cnt + 6'h1;
         unique case (s_q.st)
            swdt_pkg::SWDT_IDLE: begin
               s_d.dio_oe = 1'b0;
               s_d.cnt = 6'h0;
               if (din_w && !s_q.in_lreset) begin
                  s_d.st = swdt_pkg::SWDT_HDR;
               end
            end
            swdt_pkg::SWDT_HDR: begin
               s_d.hdr[s_q.cnt[2:0]] = din_w;
               if (s_q.cnt == swdt_pkg::HDR_LAST) begin
                  s_d.cnt = 6'h0;
                  if (hdr_bad_w) begin
                     // Silent drop keeps the line free for the host's recovery
                     s_d.st = swdt_pkg::SWDT_IDLE;
                     s_d.sts_herr = 1'b1;
                  end else begin
                     s_d.st = swdt_pkg::SWDT_ACK;
                     s_d.ack = pick_ack(s_q);
                     s_d.done = 1'b0;
                     s_d.sh = s_q.rdata;
                  end
               end
            end
            swdt_pkg::SWDT_ACK: begin
               s_d.dio_oe = 1'b1;
               s_d.dio_out = s_q.ack[s_q.cnt[1:0]];
               if (s_q.cnt == swdt_pkg::ACK_LAST) begin
                  s_d.cnt = 6'h0;
                  if (s_q.hdr[swdt_pkg::HDR_RNW] && s_q.ack == swdt_pkg::ACK_OK) begin
                     s_d.st = swdt_pkg::SWDT_RD;
                  end else begin
                     s_d.st = swdt_pkg::SWDT_TRN;
                  end
               end
            end
            swdt_pkg::SWDT_TRN: begin
               s_d.dio_oe = 1'b0;
               s_d.cnt = 6'h0;
               if (s_q.done) begin
                  s_d.st = swdt_pkg::SWDT_IDLE;
               end else if (!s_q.hdr[swdt_pkg::HDR_RNW] && (s_q.ack == swdt_pkg::ACK_OK ||
                            s_q.ack == swdt_pkg::ACK_WAIT)) begin
                  s_d.st = swdt_pkg::SWDT_WR;
               end else if (s_q.ack == swdt_pkg::ACK_WAIT) begin
                  s_d.st = swdt_pkg::SWDT_SKIP;
               end else begin
                  s_d.st = swdt_pkg::SWDT_IDLE;
               end
            end
            swdt_pkg::SWDT_RD: begin
               s_d.dio_oe = 1'b1;
               if (s_q.cnt == swdt_pkg::DATA_LAST) begin
                  // Word latched at header end, so a bus write cannot spoil the parity
                  s_d.dio_out = par32(s_q.sh);
                  s_d.st = swdt_pkg::SWDT_TRN;
                  s_d.done = 1'b1;
                  s_d.pend = 1'b1;
                  s_d.last_hdr = s_q.hdr[swdt_pkg::HDR_A3:swdt_pkg::HDR_APNDP];
               end else begin
                  s_d.dio_out = s_q.sh[0];
                  s_d.sh = {s_q.sh[0], s_q.sh[31:1]};
               end
            end
            swdt_pkg::SWDT_WR: begin
               if (s_q.cnt == swdt_pkg::DATA_LAST) begin
                  s_d.st = swdt_pkg::SWDT_IDLE;
                  if (s_q.ack == swdt_pkg::ACK_OK) begin
                     if (din_w != par32(s_q.sh)) begin
                        s_d.fault_pend = 1'b1;
                        s_d.sts_perr = 1'b1;
                     end else begin
                        s_d.wdata = s_q.sh;
                        s_d.pend = 1'b1;
                        s_d.last_hdr = s_q.hdr[swdt_pkg::HDR_A3:swdt_pkg::HDR_APNDP];
                     end
                  end
               end else begin
                  s_d.sh = {din_w, s_q.sh[31:1]};
               end
            end
            swdt_pkg::SWDT_SKIP: begin
               s_d.dio_oe = 1'b0;
               if (s_q.cnt == swdt_pkg::DATA_LAST) begin
                  s_d.st = swdt_pkg::SWDT_TRN;
                  s_d.done = 1'b1;
               end
            end
            default: begin
               s_d.st = swdt_pkg::SWDT_IDLE;
               s_d.dio_oe = 1'b0;
            end
         endcase
         // Line reset overrides any packet in progress
         if (din_w && s_q.hi_cnt == swdt_pkg::LRESET_CLOCKS - 6'h1) begin
            s_d.in_lreset = 1'b1;
            s_d.sts_lrst = 1'b1;
            s_d.fault_pend = 1'b0;
            s_d.st = swdt_pkg::SWDT_IDLE;
            s_d.dio_oe = 1'b0;
         end else if (!din_w) begin
            s_d.in_lreset = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '0;
         // All ones: no false clock rise after reset whatever the pin level
         s_q.clk_sync <= 3'h7;
         s_q.st <= swdt_pkg::SWDT_IDLE;
         s_q.ctrl <= swdt_pkg::CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign swdio_out = s_q.dio_out;
   assign swdio_oe_out = s_q.dio_oe;
   assign avs_readdata_out = s_q.av_rdata;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~s_q.av_ack;

   a_lreset_count: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(s_q.in_lreset) |-> $past(s_q.hi_cnt) == swdt_pkg::LRESET_CLOCKS - 6'h1)
      else $error("line reset entered before fifty high clocks");

   a_hdr_err_silent: assert property (@(posedge clk_in) disable iff (rst_in)
      hdr_bad_w |=> !swdio_oe_out [*8])
      else $error("target drove the line after a bad header");

   a_ack_fault_code: assert property (@(posedge clk_in) disable iff (rst_in)
      (rise_w && s_q.st == swdt_pkg::SWDT_ACK && s_q.fault_pend)
      |-> s_q.ack == swdt_pkg::ACK_FAULT)
      else $error("pending fault not reported in acknowledge");

   a_perr_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      (rise_w && s_q.st == swdt_pkg::SWDT_WR && s_q.cnt == swdt_pkg::DATA_LAST
       && s_q.ack == swdt_pkg::ACK_OK && din_w != par32(s_q.sh))
      |=> s_q.fault_pend && s_q.sts_perr && s_q.wdata == $past(s_q.wdata))
      else $error("write parity error not turned into fault");

   a_drive_on_rise: assert property (@(posedge clk_in) disable iff (rst_in)
      ($changed(swdio_out) || $changed(swdio_oe_out)) |-> $past(rise_w))
      else $error("data line changed away from a rising clock edge");

   a_data_ok_only: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_q.st == swdt_pkg::SWDT_RD) |-> s_q.ack == swdt_pkg::ACK_OK)
      else $error("read data phase without OK acknowledge");

   a_wait_float: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_q.st == swdt_pkg::SWDT_SKIP) |-> !swdio_oe_out)
      else $error("line driven during a skipped read");

   a_lsb_first: assert property (@(posedge clk_in) disable iff (rst_in)
      (rise_w && s_q.st == swdt_pkg::SWDT_RD && s_q.cnt < swdt_pkg::DATA_LAST)
      |=> swdio_out == $past(s_q.sh[0]) && swdio_oe_out)
      else $error("read data not sent low bit first");

   a_write_sample: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(s_q.wdata) |-> $past(rise_w) && $past(s_q.st) == swdt_pkg::SWDT_WR)
      else $error("write data stored outside a rising edge");

   a_ack_on_rise: assert property (@(posedge clk_in) disable iff (rst_in)
      (rise_w && s_q.st == swdt_pkg::SWDT_ACK && s_q.cnt == 6'h0)
      |=> swdio_oe_out && swdio_out == $past(s_q.ack[0]))
      else $error("acknowledge not started on first rising edge");

endmodule : swdt_target

/* File: verilog/swdt_pkg.sv */
// Constants and types for the serial wire debug target port
package swdt_pkg;

   // Avalon register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_RDATA = 4'h8;
   localparam logic [3:0] OFS_WDATA = 4'hc;

   // CTRL field positions
   localparam int CTRL_HOLD_BIT = 0;
   localparam int CTRL_WPEND_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // STATUS field positions
   localparam int STS_PEND_BIT = 0;
   localparam int STS_PERR_BIT = 1;
   localparam int STS_HERR_BIT = 2;
   localparam int STS_LRST_BIT = 3;
   localparam int STS_FAULT_BIT = 4;
   localparam int STS_INRST_BIT = 5;
   localparam int STS_HDR_LSB = 8;

   // Acknowledge codes, bit 0 goes out first
   localparam logic [2:0] ACK_OK = 3'h1;
   localparam logic [2:0] ACK_WAIT = 3'h2;
   localparam logic [2:0] ACK_FAULT = 3'h4;
   localparam logic [2:0] ACK_NACK = 3'h7;

   // Header bit positions after the start bit
   localparam int HDR_APNDP = 0;
   localparam int HDR_RNW = 1;
   localparam int HDR_A2 = 2;
   localparam int HDR_A3 = 3;
   localparam int HDR_PAR = 4;
   localparam int HDR_STOP = 5;
   localparam int HDR_PARK = 6;
   localparam logic [5:0] HDR_LAST = 6'h06;
   localparam logic [5:0] ACK_LAST = 6'h02;

   // Counts in link clock cycles
   localparam int PACKET_CLOCKS = 46;
   localparam int DATA_BITS = 32;
   localparam logic [5:0] DATA_LAST = 6'h20;
   localparam logic [5:0] LRESET_CLOCKS = 6'h32;

   typedef enum logic [6:0] {
      SWDT_IDLE = 7'h01,
      SWDT_HDR = 7'h02,
      SWDT_ACK = 7'h04,
      SWDT_TRN = 7'h08,
      SWDT_RD = 7'h10,
      SWDT_WR = 7'h20,
      SWDT_SKIP = 7'h40
   } swdt_st_type;

   typedef struct packed {
      logic [2:0] clk_sync;
      logic [1:0] dio_sync;
      swdt_st_type st;
      logic [5:0] cnt;
      logic [5:0] hi_cnt;
      logic in_lreset;
      logic [6:0] hdr;
      logic [2:0] ack;
      logic done;
      logic [31:0] sh;
      logic dio_out;
      logic dio_oe;
      logic [1:0] ctrl;
      logic pend;
      logic sts_perr;
      logic sts_herr;
      logic sts_lrst;
      logic fault_pend;
      logic [3:0] last_hdr;
      logic [31:0] rdata;
      logic [31:0] wdata;
      logic av_ack;
      logic [31:0] av_rdata;
   } swdt_state_type;

endpackage : swdt_pkg

/* File: dv/swdt_host.sv */
// Host programmer model: drives the link clock and the shared data line
`timescale 1ns/10ps
module swdt_host (
   input wire logic clk_in,
   input wire logic dio_in,
   output logic swclk_out,
   output logic dio_out,
   output logic oe_out
);
   initial begin
      swclk_out = 1'b1;
      dio_out = 1'b0;
      oe_out = 1'b1;
   end

   // One link cycle, fall then rise; clock stands high between calls
   task automatic cyc(input logic drv, input logic b, output logic s);
      @(posedge clk_in);
      swclk_out <= 1'b0;
      oe_out <= drv;
      dio_out <= b;
      repeat (3) @(posedge clk_in);
      // Late in the low half, so a slow target edge is already settled
      @(negedge clk_in);
      s = dio_in;
      @(posedge clk_in);
      swclk_out <= 1'b1;
      repeat (3) @(posedge clk_in);
   endtask : cyc

   // h is {A3, A2, RnW, APnDP}; bad[0] spoils header parity, bad[1] data parity
   task automatic packet(input logic [3:0] h, input logic [31:0] wd, input logic [1:0] bad,
                         output logic [2:0] ack, output logic [31:0] rd, output logic pok);
      logic [7:0] hb;
      logic s;
      logic p;
      hb = {1'b1, 1'b0, ^h ^ bad[0], h, 1'b1};
      rd = 32'h0;
      p = 1'b0;
      for (int i = 0; i < 8; i++) cyc(1'b1, hb[i], s);
      cyc(1'b0, 1'b0, s);
      for (int i = 0; i < 3; i++) begin
         cyc(1'b0, 1'b0, s);
         ack[i] = s;
      end
      if (ack === swdt_pkg::ACK_OK || ack === swdt_pkg::ACK_WAIT) begin
         for (int i = 0; i < 33; i++) begin
            if (h[1]) begin
               cyc(1'b0, 1'b0, s);
               if (i < 32) rd[i] = s;
               else p = s;
            end else begin
               cyc(1'b1, (i < 32) ? wd[i] : (^wd ^ bad[1]), s);
            end
         end
         cyc(1'b0, 1'b0, s);
      end
      pok = (^rd === p);
      repeat (3) cyc(1'b1, 1'b0, s);
   endtask : packet

   task automatic line_reset();
      logic s;
      repeat (52) cyc(1'b1, 1'b1, s);
      repeat (2) cyc(1'b1, 1'b0, s);
   endtask : line_reset
endmodule : swdt_host

/* File: dv/testbench.sv */
// Self-checking bench: register port and link packets against the host model
`timescale 1ns/10ps
module testbench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic swclk, host_dio, host_oe, swdio_out, swdio_oe_out, dio, pok;
   logic [3:0] avs_address_in = 4'h0;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [31:0] avs_readdata_out, rd, q;
   logic avs_waitrequest_out;
   logic [2:0] ack;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   always #12.5 clk_in = ~clk_in;
   // Released line is pulled low, the idle level
   assign dio = swdio_oe_out ? swdio_out : (host_oe ? host_dio : 1'b0);

   swdt_target i_swdt_target (
      .clk_in(clk_in), .rst_in(rst_in), .swclk_in(swclk), .swdio_in(dio),
      .swdio_out(swdio_out), .swdio_oe_out(swdio_oe_out),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out)
   );
   swdt_host i_swdt_host (
      .clk_in(clk_in), .dio_in(dio), .swclk_out(swclk), .dio_out(host_dio), .oe_out(host_oe)
   );

   task automatic stop_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Entered just after a rising edge; holds the request until waitrequest is low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      // Waitrequest and read data are both taken at the accepting rising edge
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0, "bus timeout");
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_in);
   endtask : av

   task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
      av(1'b0, a, 32'h0);
      chk(q & m, e, what);
   endtask : rdchk

   task automatic pkt(input logic [3:0] h, input logic [31:0] wd, input logic [1:0] bad,
                      input logic [2:0] ea, input logic [31:0] er);
      i_swdt_host.packet(h, wd, bad, ack, rd, pok);
      chk({29'h0, ack}, {29'h0, ea}, "ack");
      chk(rd, er, "read data");
   endtask : pkt

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rdchk(swdt_pkg::OFS_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
      rdchk(swdt_pkg::OFS_STATUS, 32'hffffffff, 32'h0, "status reset");
      av(1'b1, 4'h2, 32'hffffffff);
      rdchk(4'h2, 32'hffffffff, 32'h0, "unmapped");
      av(1'b1, swdt_pkg::OFS_WDATA, 32'h11111111);
      rdchk(swdt_pkg::OFS_WDATA, 32'hffffffff, 32'h0, "wdata read only");
      $display("test registers done");
      av(1'b1, swdt_pkg::OFS_RDATA, 32'ha5c30f96);
      pkt(4'h7, 32'h0, 2'b00, swdt_pkg::ACK_OK, 32'ha5c30f96);
      chk({31'h0, pok}, 32'h1, "read parity");
      rdchk(swdt_pkg::OFS_STATUS, 32'hffffffff, 32'h701, "status after read");
      pkt(4'h8, 32'h12345678, 2'b00, swdt_pkg::ACK_OK, 32'h0);
      rdchk(swdt_pkg::OFS_WDATA, 32'hffffffff, 32'h12345678, "write data");
      rdchk(swdt_pkg::OFS_STATUS, 32'hffffffff, 32'h801, "status after write");
      $display("test ok packets done");
      av(1'b1, swdt_pkg::OFS_CTRL, 32'h1);
      for (int i = 0; i < 4; i++)
         pkt(i[0] ? 4'h5 : 4'h7, 32'hdeadbeef, 2'b00, swdt_pkg::ACK_WAIT, 32'h0);
      rdchk(swdt_pkg::OFS_WDATA, 32'hffffffff, 32'h12345678, "write ignored");
      av(1'b1, swdt_pkg::OFS_CTRL, 32'h2);
      pkt(4'h7, 32'h0, 2'b00, swdt_pkg::ACK_WAIT, 32'h0);
      av(1'b1, swdt_pkg::OFS_STATUS, 32'h1);
      pkt(4'h7, 32'h0, 2'b00, swdt_pkg::ACK_OK, 32'ha5c30f96);
      av(1'b1, swdt_pkg::OFS_CTRL, 32'h0);
      $display("test wait done");
      pkt(4'h7, 32'h0, 2'b01, 3'h0, 32'h0);
      rdchk(swdt_pkg::OFS_STATUS, 32'hffffffff, 32'h705, "header error");
      av(1'b1, swdt_pkg::OFS_STATUS, 32'h5);
      $display("test header parity done");
      pkt(4'h5, 32'h0f0f0f0f, 2'b10, swdt_pkg::ACK_OK, 32'h0);
      pkt(4'h7, 32'h0, 2'b00, swdt_pkg::ACK_FAULT, 32'h0);
      pkt(4'h7, 32'h0, 2'b00, swdt_pkg::ACK_FAULT, 32'h0);
      rdchk(swdt_pkg::OFS_STATUS, 32'h1f, 32'h12, "fault status");
      $display("test data parity done");
      i_swdt_host.line_reset();
      rdchk(swdt_pkg::OFS_STATUS, 32'h38, 32'h08, "line reset status");
      pkt(4'h7, 32'h0, 2'b00, swdt_pkg::ACK_OK, 32'ha5c30f96);
      $display("test line reset done");
      stop_test();
   end
endmodule : testbench
